/* ecmc_main_control.sv */
// Purpose: Group 0 main control register of the echo canceller block
// Assumes: Classic Wishbone, 8-bit port, byte addresses, one clock
// Notes: Rules below; the logic of this file and its submodules keeps them
// Functional notes
// - Outputs enabled when bit AND pin high
// - Either low puts outputs high impedance
// - Output enable exists only in group 0
// - Mask bit suppresses all tone interrupts
// - Mask clear lets tone interrupts through
// - Global mask exists only in group 0
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ecmc_regs.svh"
module ecmc_main_control
#(
  parameter int NDET = 4
)
(
  input wire logic clk,
  input wire logic resetn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic wb_sel_i,
  input wire logic [7:0] wb_dat_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  // Canceller register writes
  output logic [1:0] ec_grp_we,
  output logic [5:0] ec_addr,
  output logic [7:0] ec_data,
  // Stored control fields for the cancellers
  output logic group_power_on,
  output logic law_sel,
  output logic format_sel,
  output logic tone_a_irq_mask,
  output logic tone_b_irq_mask,
  // Output enable pin and PCM outputs
  input wire logic output_drive_enable_pin,
  input wire logic rout_d,
  input wire logic sout_d,
  output logic rout_o,
  output logic rout_oe,
  output logic sout_o,
  output logic sout_oe,
  // Tone detector interrupts
  input wire logic [NDET-1:0] tone_irq,
  output logic tone_irq_n
);
  ecmc_pkg::ecmc_top_st_t st_q; // Registered state
  ecmc_pkg::ecmc_top_st_t st_d; // Next state
  logic req; // New bus request this cycle
  logic hit; // Request targets the control register
  logic wr_hit; // Write to the control register
  logic rd_hit; // Read of the control register
  logic output_drive_enable; // Control bit
  logic tone_irq_mask_all; // Control bit
  ecmc_wr_if wr (); // Canceller write path

  // ***************************************************
  // Bus decode
  // ***************************************************
  // Ack is high for one cycle, so a held request is taken once
  assign req = wb_cyc_i && wb_stb_i && !st_q.ack;
  // Full byte address compare; the group 1 register at 401h is not here
  assign hit = wb_adr_i == `ECMC_MAIN_CTRL_ADDR;
  assign wr_hit = req && wb_we_i && wb_sel_i && hit;
  // Select gates writes only; a read always returns the whole byte
  assign rd_hit = req && !wb_we_i && hit;
  assign output_drive_enable = st_q.ctrl[`ECMC_BIT_ODE];
  assign tone_irq_mask_all = st_q.ctrl[`ECMC_BIT_MASK_ALL];

  // ***************************************************
  // Next state
  // ***************************************************
  // Register, read data, pin sampling and output drive
  always_comb
  begin
    st_d = st_q;
    // Every request, mapped or not, gets an ack
    st_d.ack = req;
    if (req)
    begin
      // Unmapped or write cycles read as zero
      st_d.rdata = 8'h00;
    end
    if (rd_hit)
    begin
      st_d.rdata = st_q.ctrl;
    end
    if (wr_hit)
    begin
      // All eight bits stored, even those used elsewhere
      st_d.ctrl = wb_dat_i;
    end
    // Pin comes from outside: two flops before use
    st_d.pin_s1 = output_drive_enable_pin;
    st_d.pin_s2 = st_q.pin_s1;
    // Enable only when both bit and pin are high
    // A registered enable costs a cycle but keeps the pad enable glitch free
    st_d.oe = output_drive_enable && st_q.pin_s2;
    st_d.rout = rout_d;
    st_d.sout = sout_d;
  end

  // ***************************************************
  // State register
  // ***************************************************
  // Synchronous reset to constants only
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      // Fields not named below take zero, their power-up level
      st_q <= '0;
      st_q.ctrl <= `ECMC_MAIN_CTRL_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  // Ack and read data come straight from flip-flops
  assign wb_ack_o = st_q.ack;
  assign wb_dat_o = st_q.rdata;
  // Stored fields go straight out; their users sit outside this block
  assign group_power_on = st_q.ctrl[`ECMC_BIT_PWR];
  assign law_sel = st_q.ctrl[`ECMC_BIT_LAW];
  assign format_sel = st_q.ctrl[`ECMC_BIT_FMT];
  assign tone_a_irq_mask = st_q.ctrl[`ECMC_BIT_TA_MASK];
  assign tone_b_irq_mask = st_q.ctrl[`ECMC_BIT_TB_MASK];
  // Data keeps toggling; the enable decides if it reaches the pad
  assign rout_o = st_q.rout;
  assign sout_o = st_q.sout;
  // One enable for both outputs; other groups have no such bit
  assign rout_oe = st_q.oe;
  assign sout_oe = st_q.oe;

  // ***************************************************
  // Canceller write path
  // ***************************************************
  // Bus writes below the canceller top go to the fan-out
  assign wr.valid = req && wb_we_i && wb_sel_i;
  assign wr.addr = wb_adr_i;
  assign wr.data = wb_dat_i;
  assign wr.bcast = st_q.ctrl[`ECMC_BIT_BCAST];

  // Group steering; its one cycle lines ec_grp_we up with wb_ack_o
  ecmc_wr_fanout u_fanout
  (
    .clk(clk),
    .resetn(resetn),
    .req(wr),
    .ec_grp_we(ec_grp_we),
    .ec_addr(ec_addr),
    .ec_data(ec_data)
  );

  // ***************************************************
  // Interrupt masking
  // ***************************************************
  // Mask lives only here, not in group 1
  // Per-detector masks are only exported; this line obeys the global mask
  ecmc_irq_gate #(.NDET(NDET)) u_irq
  (
    .clk(clk),
    .resetn(resetn),
    .tone_irq(tone_irq),
    .mask_all(tone_irq_mask_all),
    .tone_irq_n(tone_irq_n)
  );

  // ***************************************************
  // Assertions
  // ***************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // Attempts that start on the release edge still see the reset state,
  // so antecedents are chosen to be false there

  // Reset puts the register at its power-up value
  a_reset_value: assert property (disable iff (1'b0)
    !resetn |=> st_q.ctrl == `ECMC_MAIN_CTRL_RESET)
    else $error("control not zero after reset");

  // A write lands in the register
  a_write_store: assert property (wr_hit |=> st_q.ctrl == $past(wb_dat_i))
    else $error("control write lost");

  // A read returns the stored byte with the ack
  a_read_back: assert property (rd_hit |=> wb_ack_o && wb_dat_o == $past(st_q.ctrl))
    else $error("read data differs from register");

  // Ack lasts exactly one cycle
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");

  // Broadcast mirrors group 0 writes to both groups
  a_bcast_all: assert property (wr.valid && wr.bcast && wb_adr_i < `ECMC_GRP_SPAN
    |=> ec_grp_we == 2'h3 && ec_data == $past(wb_dat_i))
    else $error("broadcast write not mirrored");

  // Without broadcast only group 0 is written
  a_bcast_off: assert property (wr.valid && !wr.bcast && wb_adr_i < `ECMC_GRP_SPAN
    |=> ec_grp_we == 2'h1)
    else $error("local write reached other group");

  // Bit and synchronised pin both high enable the outputs
  a_oe_and: assert property (output_drive_enable && st_q.pin_s2 |=> rout_oe && sout_oe)
    else $error("outputs not enabled");

  // Bit low turns outputs off next cycle
  a_oe_bit_off: assert property (!output_drive_enable |=> !rout_oe && !sout_oe)
    else $error("outputs driven with bit low");

  // Pin low three cycles turns outputs off
  a_oe_pin_off: assert property (!output_drive_enable_pin [*3] |=> !rout_oe)
    else $error("outputs driven with pin low");

  // Mask set keeps the interrupt quiet
  a_mask_quiet: assert property (tone_irq_mask_all |=> tone_irq_n)
    else $error("interrupt while masked");

  // Mask clear passes a detector request
  a_mask_pass: assert property (!tone_irq_mask_all && |tone_irq |=> !tone_irq_n)
    else $error("interrupt lost while unmasked");

  // Accesses elsewhere leave the register alone
  a_other_addr: assert property (req && !hit |=> $stable(st_q.ctrl))
    else $error("control changed by other address");

  // Every taken request is answered in the next cycle
  a_ack_next: assert property (req |=> wb_ack_o)
    else $error("request not acknowledged");

  // No ack without a taken request
  a_ack_idle: assert property (!req |=> !wb_ack_o)
    else $error("ack without request");

  // A write without byte select leaves the register alone
  a_sel_gate: assert property (req && wb_we_i && !wb_sel_i |=> $stable(st_q.ctrl))
    else $error("control written without select");

  // Writes and other addresses read back as zero
  a_read_zero: assert property (req && !rd_hit |=> wb_dat_o == 8'h00)
    else $error("read data not zero");

  // Only a write to the register changes it
  a_ctrl_hold: assert property (!wr_hit |=> $stable(st_q.ctrl))
    else $error("control changed without write");

  // Group 1 writes reach group 1 only, whatever the broadcast bit
  a_grp1_only: assert property (wr.valid && wb_adr_i >= `ECMC_GRP_SPAN
    && wb_adr_i < `ECMC_EC_TOP |=> ec_grp_we == 2'h2)
    else $error("group 1 write misrouted");

  // Nothing outside the canceller space reaches the cancellers
  a_fan_quiet: assert property (!(wr.valid && wb_adr_i < `ECMC_EC_TOP)
    |=> ec_grp_we == 2'h0)
    else $error("stray canceller write");

  // Canceller offset and data follow the bus write
  a_fan_word: assert property (wr.valid && wb_adr_i < `ECMC_EC_TOP
    |=> {6'h00, ec_addr} == ($past(wb_adr_i) & 12'h03f) && ec_data == $past(wb_dat_i))
    else $error("canceller offset or data wrong");

  // Canceller strobes last one cycle
  a_fan_pulse: assert property (ec_grp_we != 2'h0 |=> ec_grp_we == 2'h0)
    else $error("canceller strobe held");

  // Synchronised pin low turns outputs off next cycle
  a_oe_sync_off: assert property (!st_q.pin_s2 |=> !rout_oe && !sout_oe)
    else $error("outputs driven with synced pin low");

  // Clearing the bit turns the outputs off two cycles later
  a_ode_write_off: assert property (wr_hit && !wb_dat_i[`ECMC_BIT_ODE]
    |=> ##1 !rout_oe && !sout_oe)
    else $error("outputs still driven after bit cleared");

  // PCM data passes with one cycle of delay
  a_pcm_data: assert property (resetn |=> rout_o == $past(rout_d)
    && sout_o == $past(sout_d))
    else $error("PCM data not carried");

  // Without a detector request the line stays idle
  a_irq_idle: assert property (!(|tone_irq) |=> tone_irq_n)
    else $error("interrupt without request");

  // Main scenarios
  c_bcast_write: cover property (wr.valid && wr.bcast ##1 ec_grp_we == 2'h3);
  c_read: cover property (rd_hit ##1 wb_ack_o);
  c_outputs_on: cover property (!rout_oe ##1 rout_oe);
  c_irq: cover property (tone_irq_n ##1 !tone_irq_n);
  c_masked: cover property (tone_irq_mask_all && |tone_irq ##1 tone_irq_n);
endmodule
`default_nettype wire

/* ecmc_regs.svh */
// Purpose: Offsets, field positions, reset values for the echo group control
// Assumes: 12-bit byte address, 8-bit data
// Notes: Definitions only
`ifndef ECMC_REGS_SVH
`define ECMC_REGS_SVH

// ***************************************************
// Register map
// ***************************************************
// Group 0 main control register byte address
`define ECMC_MAIN_CTRL_ADDR 12'h400
// Main control value after reset
`define ECMC_MAIN_CTRL_RESET 8'h00
// Span of one group's canceller registers
`define ECMC_GRP_SPAN 12'h040
// First address above all canceller registers (two groups)
`define ECMC_EC_TOP 12'h080

// ***************************************************
// Main control field positions
// ***************************************************
`define ECMC_BIT_PWR 0
`define ECMC_BIT_LAW 1
`define ECMC_BIT_FMT 2
`define ECMC_BIT_TA_MASK 3
`define ECMC_BIT_TB_MASK 4
`define ECMC_BIT_MASK_ALL 5
`define ECMC_BIT_ODE 6
`define ECMC_BIT_BCAST 7

`endif

/* ecmc_pkg.sv */
// Purpose: Types shared by the echo group control modules
// Assumes: Constants live in ecmc_regs.svh
// Notes: State records of the top module and the write fan-out
package ecmc_pkg;

  // One register byte
  typedef logic [7:0] ecmc_byte_t;

  // State of the top module
  typedef struct packed {
    logic [7:0] ctrl;
    logic ack;
    logic [7:0] rdata;
    logic pin_s1;
    logic pin_s2;
    logic oe;
    logic rout;
    logic sout;
  } ecmc_top_st_t;

  // State of the write fan-out
  typedef struct packed {
    logic [1:0] grp_we;
    logic [5:0] addr;
    logic [7:0] data;
  } ecmc_fan_st_t;

endpackage

/* ecmc_wr_if.sv */
// Purpose: Carries canceller register writes to the fan-out
// Assumes: Same clock on both sides
// Notes: valid is a one-cycle strobe
`timescale 1ns/1ps
`default_nettype none
interface ecmc_wr_if;
  logic valid; // Write strobe
  logic [11:0] addr; // Byte address
  logic [7:0] data; // Write data
  logic bcast; // Mirror group 0 writes
  modport src (output valid, output addr, output data, output bcast);
  modport dst (input valid, input addr, input data, input bcast);
endinterface
`default_nettype wire

/* ecmc_wr_fanout.sv */
// Purpose: Steers canceller writes to one group or to all groups
// Assumes: Groups are ECMC_GRP_SPAN apart from address 0
// Notes: One cycle of latency, outputs from flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "ecmc_regs.svh"
module ecmc_wr_fanout
(
  input wire logic clk,
  input wire logic resetn,
  ecmc_wr_if.dst req,
  output logic [1:0] ec_grp_we,
  output logic [5:0] ec_addr,
  output logic [7:0] ec_data
);
  ecmc_pkg::ecmc_fan_st_t st_q; // Registered state
  ecmc_pkg::ecmc_fan_st_t st_d; // Next state
  logic in_range; // Address hits canceller space
  logic grp1; // Address lies in group 1

  // ***************************************************
  // Group decode
  // ***************************************************
  // Group 0 local writes mirror when broadcast is set
  always_comb
  begin
    in_range = req.addr < `ECMC_EC_TOP;
    grp1 = req.addr >= `ECMC_GRP_SPAN;
    st_d = st_q;
    st_d.grp_we = 2'h0;
    if (req.valid && in_range)
    begin
      // Local offset is the same in every group
      st_d.addr = req.addr[5:0];
      st_d.data = req.data;
      if (grp1)
      begin
        st_d.grp_we = 2'h2; // Group 1 writes never mirror
      end
      else if (req.bcast)
      begin
        st_d.grp_we = 2'h3;
      end
      else
      begin
        st_d.grp_we = 2'h1;
      end
    end
  end

  // Register the state
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign ec_grp_we = st_q.grp_we;
  assign ec_addr = st_q.addr;
  assign ec_data = st_q.data;
endmodule
`default_nettype wire

/* ecmc_irq_gate.sv */
// Purpose: Gates tone detector interrupts with the global mask
// Assumes: Detector requests come from logic on clk, active high
// Notes: Output active low, one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module ecmc_irq_gate
#(
  parameter int NDET = 4
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [NDET-1:0] tone_irq,
  input wire logic mask_all,
  output logic tone_irq_n
);
  logic st_q; // Registered interrupt, active high
  logic st_d; // Next value

  // ***************************************************
  // Masking
  // ***************************************************
  // Detectors keep running; only the request is held back
  always_comb
  begin
    st_d = (|tone_irq) && !mask_all;
  end

  // Register the request
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      st_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign tone_irq_n = !st_q;
endmodule
`default_nettype wire

/* ecmc_pcm_sink.sv */
// Purpose: Far-end model of one tri-state PCM output line
// Assumes: Driver enable is active high
// Notes: Released line shows the inverse of the last driven bit
`timescale 1ns/1ps
`default_nettype none
module ecmc_pcm_sink
(
  input wire logic clk,
  input wire logic d,
  input wire logic oe,
  output logic line
);
  // Last bit seen while driven
  logic last_q = 1'h0;
  // Remember the driven level
  always_ff @(posedge clk)
  begin
    if (oe)
    begin
      last_q <= d;
    end
  end
  // Inverse when released, so a stale value never looks like a match
  always_comb
  begin
    line = oe ? d : ~last_q;
  end
endmodule
`default_nettype wire

/* ecmc_main_control_tb_top.sv */
// Purpose: Self-checking bench of the group 0 main control register
// Assumes: Slave acks each request; every wait is bounded
// Notes: Inputs change by non-blocking assignment at rising edges
`timescale 1ns/1ps
`default_nettype none
module ecmc_main_control_tb_top;
  // Bus and pin drives
  logic clk, resetn, cyc, stb, we, sel, pin, rd, sd, ack;
  logic [11:0] adr;
  logic [7:0] wdat, dato, rdat, edat;
  logic [1:0] gwe, s_gwe;
  logic [5:0] eadr;
  logic [3:0] tirq;
  logic pwr, law, fmt, tam, tbm, ro, roe, so, soe, irqn, rline, sline;
  int fails, num_checks;
  logic bsel; // Byte select that the next bus call drives

  ecmc_main_control #(.NDET(4)) u_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(dato), .wb_ack_o(ack), .ec_grp_we(gwe), .ec_addr(eadr), .ec_data(edat),
    .group_power_on(pwr), .law_sel(law), .format_sel(fmt), .tone_a_irq_mask(tam),
    .tone_b_irq_mask(tbm), .output_drive_enable_pin(pin), .rout_d(rd), .sout_d(sd),
    .rout_o(ro), .rout_oe(roe), .sout_o(so), .sout_oe(soe), .tone_irq(tirq),
    .tone_irq_n(irqn));
  ecmc_pcm_sink u_rsink (.clk(clk), .d(ro), .oe(roe), .line(rline));
  ecmc_pcm_sink u_ssink (.clk(clk), .d(so), .oe(soe), .line(sline));

  // ***********************
  // Tasks
  // ***********************
  // Compare one byte
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Verdict and end of run
  task close_out;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // One classic cycle; entered just after a rising edge
  task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    n = 0;
    @(posedge clk);
    // Values read here are those sampled at this edge
    while (ack !== 1'h1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 20)
    begin
      fails++;
      close_out();
    end
    rdat = dato;
    s_gwe = gwe;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk);
  endtask

  // ***********************
  // Stimulus
  // ***********************
  // Free-running clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  // Main sequence
  initial
  begin
    resetn = 1'h0;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    sel = 1'h0;
    adr = 12'h000;
    wdat = 8'h00;
    pin = 1'h0;
    rd = 1'h1;
    sd = 1'h0;
    tirq = 4'h0;
    bsel = 1'h1;
    fails = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    bus(1'h0, 12'h400, 8'h00);
    chk(rdat, 8'h00);
    bus(1'h1, 12'h400, 8'ha5);
    bus(1'h0, 12'h400, 8'h00);
    chk(rdat, 8'ha5);
    chk({3'h0, tbm, tam, fmt, law, pwr}, 8'h05);
    bus(1'h0, 12'h401, 8'h00);
    chk(rdat, 8'h00);
    // A write without byte select is acked but stores nothing
    bsel = 1'h0;
    bus(1'h1, 12'h400, 8'h3c);
    bsel = 1'h1;
    bus(1'h0, 12'h400, 8'h00);
    chk(rdat, 8'ha5);
    // Canceller writes, single then mirrored then group 1
    bus(1'h1, 12'h400, 8'h00);
    bus(1'h1, 12'h010, 8'h3c);
    chk({6'h0, s_gwe}, 8'h01);
    chk({2'h0, eadr}, 8'h10);
    chk(edat, 8'h3c);
    bus(1'h1, 12'h400, 8'h80);
    bus(1'h1, 12'h03f, 8'hc3);
    chk({6'h0, s_gwe}, 8'h03);
    bus(1'h1, 12'h050, 8'h77);
    chk({6'h0, s_gwe}, 8'h02);
    // Every combination of the enable bit and the pin
    for (int i = 0; i < 4; i++)
    begin
      bus(1'h1, 12'h400, {1'h0, i[1], 6'h00});
      pin <= i[0];
      repeat (5) @(posedge clk);
      chk({6'h0, roe, soe}, (i == 3) ? 8'h03 : 8'h00);
      if (i == 3)
      begin
        chk({6'h0, rline, sline}, {6'h0, rd, sd});
        // Flip both data inputs; the enabled lines must follow
        rd <= 1'h0;
        sd <= 1'h1;
        repeat (3) @(posedge clk);
        chk({6'h0, rline, sline}, 8'h01);
      end
    end
    // A second register cannot enable the outputs
    bus(1'h1, 12'h400, 8'h00);
    bus(1'h1, 12'h401, 8'h60);
    repeat (5) @(posedge clk);
    chk({6'h0, roe, soe}, 8'h00);
    tirq <= 4'h2;
    repeat (3) @(posedge clk);
    chk({7'h0, irqn}, 8'h00);
    bus(1'h1, 12'h400, 8'h20);
    repeat (3) @(posedge clk);
    chk({7'h0, irqn}, 8'h01);
    bus(1'h1, 12'h400, 8'h00);
    repeat (3) @(posedge clk);
    chk({7'h0, irqn}, 8'h00);
    // Reset in mid-run; detectors quiet so no request meets the release edge
    tirq <= 4'h0;
    bus(1'h1, 12'h400, 8'hff);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    bus(1'h0, 12'h400, 8'h00);
    chk(rdat, 8'h00);
    chk({6'h0, roe, soe}, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
